//--- rtl/burst_sram_defs.svh
`ifndef BURST_SRAM_DEFS_SVH
`define BURST_SRAM_DEFS_SVH

// ----------------------------------------
// geometry
// ----------------------------------------
`define ADDR_W 6
`define LANES 4
`define LANE_W 9
`define DATA_W 36
`define DEPTH 64

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 40
`define CLOCK_TO_DATA_DELAY_NS 6.5
`define SLEEP_ENTRY_CYCLES 2
`define SLEEP_RECOVERY_INTERVAL_CYCLES 2

`endif

//--- rtl/burst_sram_pkg.sv
package burst_sram_pkg;

  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_READ = 2'b01,
    OP_WRITE = 2'b10
  } op_t;

  typedef enum logic [1:0] {
    PWR_AWAKE = 2'b00,
    PWR_ENTER = 2'b01,
    PWR_SLEEP = 2'b10,
    PWR_EXIT = 2'b11
  } pwr_t;

  // one registered access in flight
  typedef struct packed {
    logic [1:0] op;
    logic [5:0] base;
    logic [1:0] count;
    logic fresh;
  } access_t;

endpackage

//--- rtl/flow_through_burst_sram_port.sv
`include "burst_sram_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module flow_through_burst_sram_port (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clock_qualify_n,
  input wire logic chip_select_a_n,
  input wire logic chip_select_b,
  input wire logic chip_select_c_n,
  input wire logic advance_or_load,
  input wire logic write_n,
  input wire logic [`LANES-1:0] byte_lane_write_n,
  input wire logic [`ADDR_W-1:0] address,
  input wire logic burst_order_strap,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic [`DATA_W-1:0] data_in,
  output logic [`DATA_W-1:0] data_out,
  output logic [`DATA_W-1:0] data_oe,
  output logic sleeping,
  output logic access_invalid
);

  // ----------------------------------------
  // synchronisers for pins
  // ----------------------------------------
  logic [3:0] ctl_meta_reg;
  logic [3:0] ctl_sync_reg;
  logic [`LANES+1:0] wr_meta_reg;
  logic [`LANES+1:0] wr_sync_reg;
  logic [`ADDR_W-1:0] addr_meta_reg;
  logic [`ADDR_W-1:0] addr_sync_reg;
  logic [`DATA_W-1:0] din_meta_reg;
  logic [`DATA_W-1:0] din_sync_reg;
  logic [2:0] misc_meta_reg;
  logic [2:0] misc_sync_reg;

  // reset to stalled and deselected, so nothing starts before real pins arrive
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctl_meta_reg <= 4'hF;
      ctl_sync_reg <= 4'hF;
    end else begin
      ctl_meta_reg <= {clock_qualify_n, chip_select_a_n, ~chip_select_b, chip_select_c_n};
      ctl_sync_reg <= ctl_meta_reg;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_meta_reg <= '1;
      wr_sync_reg <= '1;
    end else begin
      wr_meta_reg <= {advance_or_load, write_n, byte_lane_write_n};
      wr_sync_reg <= wr_meta_reg;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      addr_meta_reg <= '0;
      addr_sync_reg <= '0;
    end else begin
      addr_meta_reg <= address;
      addr_sync_reg <= addr_meta_reg;
    end
  end

  // data lags the command by the same two stages, so pairing is kept
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      din_meta_reg <= '0;
      din_sync_reg <= '0;
    end else begin
      din_meta_reg <= data_in;
      din_sync_reg <= din_meta_reg;
    end
  end

  // sleep must reset low, or every reset would fake a sleep request
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      misc_meta_reg <= 3'h2;
      misc_sync_reg <= 3'h2;
    end else begin
      misc_meta_reg <= {burst_order_strap, output_enable_n, sleep_request};
      misc_sync_reg <= misc_meta_reg;
    end
  end

  logic stall;
  logic selected;
  logic adv;
  logic wr_n;
  logic [`LANES-1:0] lane_n;
  logic order_interleaved;
  logic oe_n;
  logic zz;
  assign stall = ctl_sync_reg[3];
  assign selected = ~|ctl_sync_reg[2:0];
  assign adv = wr_sync_reg[`LANES+1];
  assign wr_n = wr_sync_reg[`LANES];
  assign lane_n = wr_sync_reg[`LANES-1:0];
  assign order_interleaved = misc_sync_reg[2];
  assign oe_n = misc_sync_reg[1];
  assign zz = misc_sync_reg[0];

  // ----------------------------------------
  // sleep control
  // ----------------------------------------
  burst_sram_pkg::pwr_t pwr_reg;
  logic [1:0] pwr_cnt_reg;
  logic awake;
  assign awake = (pwr_reg == burst_sram_pkg::PWR_AWAKE);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pwr_reg <= burst_sram_pkg::PWR_AWAKE;
      pwr_cnt_reg <= 2'h0;
    end else begin
      unique case (pwr_reg)
        burst_sram_pkg::PWR_AWAKE: begin
          if (zz) begin
            pwr_reg <= burst_sram_pkg::PWR_ENTER;
            pwr_cnt_reg <= 2'h0;
          end
        end
        burst_sram_pkg::PWR_ENTER: begin
          // two cycles to settle into sleep
          if (pwr_cnt_reg == 2'(`SLEEP_ENTRY_CYCLES - 1)) begin
            pwr_reg <= burst_sram_pkg::PWR_SLEEP;
          end
          pwr_cnt_reg <= pwr_cnt_reg + 2'h1;
        end
        burst_sram_pkg::PWR_SLEEP: begin
          if (!zz) begin
            pwr_reg <= burst_sram_pkg::PWR_EXIT;
            pwr_cnt_reg <= 2'h0;
          end
        end
        burst_sram_pkg::PWR_EXIT: begin
          if (pwr_cnt_reg == 2'(`SLEEP_RECOVERY_INTERVAL_CYCLES - 1)) begin
            pwr_reg <= burst_sram_pkg::PWR_AWAKE;
          end
          pwr_cnt_reg <= pwr_cnt_reg + 2'h1;
        end
      endcase
    end
  end

  assign sleeping = ~awake;

  // ----------------------------------------
  // access sequencing
  // ----------------------------------------
  burst_sram_pkg::access_t acc_reg;
  logic qualified;
  logic start;
  logic [1:0] low_bits;
  logic [`ADDR_W-1:0] cur_addr;

  assign qualified = awake && !stall;
  assign start = qualified && !adv && selected;

  // burst order from strap
  always_comb begin
    if (order_interleaved) begin
      low_bits = acc_reg.base[1:0] ^ acc_reg.count;
    end else begin
      low_bits = acc_reg.base[1:0] + acc_reg.count;
    end
  end
  assign cur_addr = {acc_reg.base[`ADDR_W-1:2], low_bits};

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      acc_reg <= '{op: burst_sram_pkg::OP_IDLE, base: '0, count: 2'h0, fresh: 1'b0};
    end else if (!awake) begin
      // pending operation dropped on sleep
      acc_reg.op <= burst_sram_pkg::OP_IDLE;
      acc_reg.fresh <= 1'b0;
    end else if (qualified) begin
      if (adv) begin
        // counter steps, selects and strobe ignored
        acc_reg.count <= acc_reg.count + 2'h1;
        acc_reg.fresh <= 1'b0;
      end else if (selected) begin
        acc_reg.base <= addr_sync_reg;
        acc_reg.count <= 2'h0;
        // direction kept for the whole burst
        acc_reg.op <= wr_n ? burst_sram_pkg::OP_READ : burst_sram_pkg::OP_WRITE;
        acc_reg.fresh <= (acc_reg.op == burst_sram_pkg::OP_IDLE);
      end else begin
        acc_reg.op <= burst_sram_pkg::OP_IDLE;
        acc_reg.fresh <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // array and byte-lane writes
  // ----------------------------------------
  logic [`DATA_W-1:0] rd_word;
  logic write_beat;

  // write data for the access taken at the previous edge lands now
  assign write_beat = qualified && (acc_reg.op == burst_sram_pkg::OP_WRITE);

  genvar g;
  generate
    for (g = 0; g < `LANES; g++) begin : g_lane
      // one store per lane, so each store has a single writer
      logic [`LANE_W-1:0] lane_mem_reg [`DEPTH];
      always_ff @(posedge mclk) begin
        // lane selects sampled on every beat
        if (write_beat && !lane_n[g]) begin
          lane_mem_reg[cur_addr] <= din_sync_reg[g*`LANE_W +: `LANE_W];
        end
      end
      assign rd_word[g*`LANE_W +: `LANE_W] = lane_mem_reg[cur_addr];
    end
  endgenerate

  // ----------------------------------------
  // data outputs
  // ----------------------------------------
  logic [`DATA_W-1:0] dout_reg;
  logic drive_reg;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dout_reg <= '0;
      drive_reg <= 1'b0;
    end else begin
      dout_reg <= rd_word;
      // write, deselect, sleep or first cycle out of deselect all float
      drive_reg <= (acc_reg.op == burst_sram_pkg::OP_READ) && awake && !acc_reg.fresh;
    end
  end

  // output enable gates the drivers; controller floats its own
  assign data_out = dout_reg;
  assign data_oe = {`DATA_W{drive_reg && !oe_n}};

  // ----------------------------------------
  // sleep hazard flag
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      access_invalid <= 1'b0;
    end else if (zz && awake && acc_reg.op != burst_sram_pkg::OP_IDLE) begin
      // set wins over a clearing start in the same cycle
      access_invalid <= 1'b1;
    end else if (start) begin
      access_invalid <= 1'b0;
    end
  end

endmodule // flow_through_burst_sram_port

`default_nettype wire

//--- bench/burst_port_assertions.sv
`include "burst_sram_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module burst_port_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clock_qualify_n,
  input wire logic chip_select_a_n,
  input wire logic advance_or_load,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic [`DATA_W-1:0] data_out,
  input wire logic [`DATA_W-1:0] data_oe,
  input wire logic sleeping,
  input wire logic access_invalid
);
  // ------
  // pin lag is two sync stages, hence the offsets
  // ------
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_OE_WHOLE: assert property (data_oe == '0 || &data_oe)
    else $error("oe bits differ");
  AST_OE_GATED: assert property (output_enable_n [*4] |-> data_oe == '0)
    else $error("driving with oe off");
  AST_DESELECT: assert property (chip_select_a_n && !advance_or_load && !clock_qualify_n
    ##1 !clock_qualify_n |-> ##3 data_oe == '0) else $error("driving after deselect");
  AST_SLEEP_QUIET: assert property (sleeping && $past(sleeping, 2) |-> data_oe == '0)
    else $error("driving asleep");
  AST_SLEEP_ENTRY: assert property ($rose(sleep_request) |-> ##[1:6] sleeping)
    else $error("sleep entry late");
  AST_SLEEP_EXIT: assert property ($fell(sleep_request) && sleeping
    |-> sleeping [*2] ##[1:8] !sleeping) else $error("sleep exit timing");
  AST_STALL_HOLD: assert property (clock_qualify_n [*4] && !sleeping
    |=> $stable(data_out)) else $error("stall moved data");
  AST_INVALID: assert property ($rose(access_invalid) |-> ##[0:4] sleeping)
    else $error("invalid without sleep");
  AST_RESET_QUIET: assert property (disable iff (1'b0) !resetn
    |-> data_oe == '0 && !sleeping) else $error("reset not quiet");
endmodule // burst_port_checker
bind flow_through_burst_sram_port burst_port_checker u_chk (.*);
`default_nettype wire

//--- bench/ctl_bus_model.sv
`include "burst_sram_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ctl_bus_model (
  input wire logic mclk,
  input wire logic drive,
  input wire logic [`DATA_W-1:0] wdata,
  input wire logic [`DATA_W-1:0] data_out,
  input wire logic [`DATA_W-1:0] data_oe,
  output logic [`DATA_W-1:0] data_in,
  output logic clash
);
  // ------
  // shared data and parity lines
  // ------
  logic [`DATA_W-1:0] last = '0;
  // released lines flip each cycle, so stale data never passes
  assign data_in = (data_oe & data_out) | (~data_oe & (drive ? wdata : ~last));
  assign clash = drive && |data_oe;
  always @(posedge mclk) last <= data_in;
endmodule // ctl_bus_model
`default_nettype wire

//--- bench/test_flow_through_burst_sram_port.sv
`include "burst_sram_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_flow_through_burst_sram_port;
  // ------
  // pins, expectation pipe, model memory
  // ------
  logic mclk = 1'h0, resetn = 1'h0, qn = 1'h1, adv = 1'h0, wn = 1'h1, st = 1'h0;
  logic oen = 1'h0, zz = 1'h0, drv = 1'h0, sleeping, access_invalid, clash;
  logic [2:0] cs = 3'h6;
  logic [3:0] ln = 4'hF, po = 4'h0;
  logic [5:0] a = 6'h00;
  logic [35:0] wd = 36'h0, data_in, data_out, data_oe;
  logic [3:0][35:0] pd = '0;
  logic [35:0] mem [64];
  int n_fail = 0, tests_run = 0, cnt = 0;
  initial forever #20 mclk = ~mclk;
  flow_through_burst_sram_port DUT (.*, .clock_qualify_n(qn), .chip_select_a_n(cs[2]),
    .chip_select_b(cs[1]), .chip_select_c_n(cs[0]), .advance_or_load(adv), .write_n(wn),
    .byte_lane_write_n(ln), .address(a), .burst_order_strap(st), .output_enable_n(oen),
    .sleep_request(zz));
  ctl_bus_model far (.*, .drive(drv), .wdata(wd));
  function automatic logic [5:0] ba(input logic [5:0] b, input int i, input logic s);
    return s ? {b[5:2], b[1:0] ^ 2'(i)} : {b[5:2], b[1:0] + 2'(i)};
  endfunction
  function automatic logic [2:0] des(); return 3'h2 ^ 3'(1 << ($urandom % 3)); endfunction
  task automatic chk(input logic [35:0] e, input logic [35:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t %h %h", $time, e, g);
    end
  endtask
  // outputs lag pins by four calls; a stall repeats the newest beat in the pipe
  task automatic cyc(input logic o, input logic [35:0] d, input logic h);
    chk({36{po[3]}}, data_oe);
    if (po[3]) chk(pd[3], data_out);
    chk(36'h0, 36'(clash));
    po = h ? {po[2:0], po[0]} : {po[2:0], o};
    pd = h ? {pd[2:0], pd[0]} : {pd[2:0], d};
    @(negedge mclk);
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      cs = des();
      adv = 1'h0;
      drv = 1'h0;
      cyc(1'h0, 36'h0, 1'h0);
    end
  endtask
  task automatic burst(input logic w, input int n, input logic [5:0] b, input logic full);
    logic [5:0] x;
    int i, g;
    idle(3);
    st = 1'($urandom);
    oen = !w && ($urandom % 4 == 0);
    for (i = 0; i <= n; i++) begin
      if (i > 0 && i < n && $urandom % 3 == 0) begin
        qn = 1'h1;
        cyc(1'h0, 36'h0, 1'h1);
        qn = 1'h0;
      end
      drv = w && i > 0;
      if (drv) begin
        x = ba(b, i - 1, st);
        wd = 36'({$urandom, $urandom});
        ln = full ? 4'h0 : 4'($urandom);
        for (g = 0; g < 4; g++) if (!ln[g]) mem[x][9*g+:9] = wd[9*g+:9];
      end
      adv = i > 0 && i < n;
      a = adv ? 6'($urandom) : b;
      {cs, wn} = adv ? 4'($urandom) : i == n ? {des(), 1'h1} : {3'h2, !w};
      cyc(!w && !oen && adv, mem[ba(b, i, st)], 1'h0);
    end
  endtask
  task automatic conclude;
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cnt++;
    if (cnt == 3000) begin
      n_fail++;
      conclude;
    end
  end
  initial begin
    int k;
    void'($urandom(95588));
    repeat (4) @(negedge mclk);
    resetn = 1'h1;
    qn = 1'h0;
    for (k = 0; k < 64; k += 4) burst(1'h1, 4, 6'(k), 1'h1);
    qn = 1'h1;
    idle(6);
    qn = 1'h0;
    repeat (40) burst(1'($urandom), 1 + $urandom % 4, 6'($urandom), 1'h0);
    idle(3);
    zz = 1'h1;
    idle(8);
    chk(36'h1, 36'(sleeping));
    zz = 1'h0;
    idle(8);
    chk(36'h0, 36'({sleeping, access_invalid}));
    // deliberate: sleep lands on a write still waiting for data
    {cs, wn, a} = {3'h2, 1'h0, 6'h00};
    cyc(1'h0, 36'h0, 1'h0);
    cs = des();
    zz = 1'h1;
    cyc(1'h0, 36'h0, 1'h0);
    idle(8);
    chk(36'h1, 36'(access_invalid));
    zz = 1'h0;
    idle(8);
    burst(1'h0, 4, 6'h08, 1'h0);
    idle(4);
    chk(36'h0, 36'(access_invalid));
    conclude;
  end
endmodule // test_flow_through_burst_sram_port
`default_nettype wire
